// ---- logic/relay_ui.sv ----
// Functional notes
// - Teach-in max below 2 m/s: four red flashes; above 10 m/s: five.
// - Short press leaves teach error; earlier full scale is kept.
// - Store mode, low and high percent thresholds, time-out 0..100 s.
// - Window mode: relay toggles at either threshold crossing.
// - Hysteresis: on at rising high threshold, off at falling low.
// - Readout: one green flash per indication cycle, red off.
// - Short presses pick parameter; green flashes one more than presses.
// - Two second hold on a shown parameter enters config; red lit.
// - Mode config alternates while held; release picks; short commits.
// - Ten seconds without a press returns to readout, value dropped.
// - Factory defaults select hysteresis mode.
// - Low threshold limited to zero up to high threshold.
// - Low entry: LED one flashes nine 1% steps, then LEDs of 10%.
// - Further hold after release flashes next LED in unit steps.
// - Short press commits shown value; repeated holds adjust again.
// - High threshold limited from low threshold up to 100%.
// - High entry starts at first LED above low threshold.
// - Relay switches only after condition outlasts the time-out.
// - Zero time-out switches the relay at once.
// - Time-out entry: flash is one second, lit LED ten seconds.
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module relay_ui
  import relay_ui_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        BUTTON_I,
  input  wire logic [6:0]  VELOCITY_I,
  input  wire logic        VEL_VALID_I,
  input  wire logic        TEACH_DONE_I,
  input  wire logic [7:0]  TEACH_MAX_I,
  input  wire logic [3:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        WE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             RELAY_O,
  output logic             LED_GREEN_O,
  output logic             LED_RED_O,
  output logic [9:0]       BAR_O,
  output logic [7:0]       FULLSCALE_O
);
  localparam int PW = $clog2(TICK_CYC);

  logic [PW-1:0]    pre_q;
  logic             tick;
  logic             btn_s1_q;
  logic             btn_s2_q;
  logic             btn_q;
  logic             btn_d1_q;
  logic [1:0]       deb_q;
  logic             deb_diff;
  logic             deb_done;
  logic [7:0]       hold_q;
  logic             held_long;
  logic             long_ev;
  logic             btn_fall;
  logic             short_ev;
  logic [9:0]       idle_q;
  logic             in_cfg;
  logic             idle_ev;
  logic [6:0]       pace_q;
  logic [6:0]       pace_top;
  logic             pace_ev;
  ui_state_type     st_q;
  logic [2:0]       sel_q;
  logic [6:0]       edit_q;
  logic             emode_q;
  logic             fine_q;
  logic             first_q;
  logic [2:0]       err_q;
  logic [6:0]       lim;
  logic [6:0]       minv;
  logic [6:0]       low_dec;
  logic [6:0]       base;
  logic [6:0]       edit_f;
  logic [6:0]       edit_dec;
  logic [6:0]       nxt_c;
  logic [6:0]       nxt_f;
  logic             c_ok;
  logic             f_ok;
  logic [6:0]       shown;
  logic             teach_slow;
  logic             teach_fast;
  logic             teach_err;
  logic             teach_ok;
  logic             mode_q;
  logic [6:0]       low_q;
  logic [6:0]       high_q;
  logic [6:0]       tmo_q;
  logic [7:0]       fs_q;
  logic             commit_mode;
  logic             commit_num;
  logic             cfg_chg;
  logic             wb_req;
  logic             wb_wr;
  logic             wr_cfg;
  logic             wr_def;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic [31:0]      cfg_word;
  logic [31:0]      stat_word;
  logic [31:0]      rdata;
  logic [6:0]       vel_q;
  logic             amode_q;
  logic [6:0]       alow_q;
  logic [6:0]       ahigh_q;
  logic             in_win;
  logic             want;
  logic [13:0]      tmo_ticks;
  logic [13:0]      persist_q;
  logic             relay_q;
  logic [4:0]       ftick_q;
  logic [3:0]       slot_q;
  logic             half_on;
  logic [6:0]       show_v;
  logic [6:0]       disp_v;
  logic [6:0]       disp_c;
  logic [6:0]       disp_f;
  logic             bar_fl;
  logic [9:0]       bar_lvl;
  logic             show_mode;
  logic             mode_shown;
  logic [9:0]       bar_d;
  logic [3:0]       green_cnt;
  logic             green_d;
  logic             red_d;
  logic             green_q;
  logic             red_q;
  logic [9:0]       bar_q;

  // ----------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------
  assign tick = (pre_q == PW'(TICK_CYC - 1));

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Push-button
  // ----------------------------------------------------------
  assign deb_diff  = btn_s2_q ^ btn_q;
  assign deb_done  = deb_diff & tick & (deb_q == DEB_TICKS - 2'h1);
  assign held_long = (hold_q == HOLD_TICKS);
  assign long_ev   = btn_q & tick & (hold_q == HOLD_TICKS - 8'h01);
  assign btn_fall  = btn_d1_q & ~btn_q;
  assign short_ev  = btn_fall & ~held_long;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_q    <= 1'b0;
      btn_d1_q <= 1'b0;
      deb_q    <= 2'h0;
      hold_q   <= 8'h00;
    end else begin
      btn_s1_q <= BUTTON_I;
      btn_s2_q <= btn_s1_q;
      btn_d1_q <= btn_q;
      if (!deb_diff) begin
        deb_q <= 2'h0;
      end else if (tick) begin
        deb_q <= deb_q + 2'h1;
      end
      if (deb_done) begin
        btn_q <= btn_s2_q;
      end
      if (!btn_q) begin
        hold_q <= 8'h00;
      end else if (tick && !held_long) begin
        hold_q <= hold_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------
  // Inactivity and sweep pace
  // ----------------------------------------------------------
  assign in_cfg   = (st_q == ST_SHOW) | (st_q == ST_MODE)
                  | (st_q == ST_EDIT);
  assign idle_ev  = in_cfg & ~btn_q & tick
                  & (idle_q == IDLE_TICKS - 10'h001);
  assign pace_top = (st_q == ST_MODE) ? ALT_TICKS : STEP_TICKS;
  assign pace_ev  = held_long & tick & (pace_q == pace_top - 7'h01);

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      idle_q <= 10'h000;
      pace_q <= 7'h00;
    end else begin
      if (!in_cfg || btn_q) begin
        idle_q <= 10'h000;
      end else if (tick) begin
        idle_q <= idle_q + 10'h001;
      end
      if (!held_long || pace_ev) begin
        pace_q <= 7'h00;
      end else if (tick) begin
        pace_q <= pace_q + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------
  // Value entry arithmetic and teach-in range check
  // ----------------------------------------------------------
  assign lim      = (sel_q == SEL_LOW) ? high_q
                  : (sel_q == SEL_TMO) ? TMO_MAX : PCT_FULL;
  assign minv     = (sel_q == SEL_HIGH) ? low_q : 7'h00;
  assign low_dec  = (low_q / DECADE) * DECADE;
  assign base     = (sel_q == SEL_HIGH) ? low_dec : 7'h00;
  assign edit_f   = edit_q % DECADE;
  assign edit_dec = edit_q - edit_f;
  assign nxt_c    = first_q ? edit_q + 7'h01 : edit_q + DECADE;
  assign nxt_f    = edit_q + 7'h01;
  assign c_ok     = (nxt_c <= lim);
  assign f_ok     = (edit_f != FINE_TOP) & (edit_q < lim);
  assign shown    = (edit_q < minv) ? minv : edit_q;

  assign teach_slow = TEACH_DONE_I & (TEACH_MAX_I < SLOW_LIMIT);
  assign teach_fast = TEACH_DONE_I & (TEACH_MAX_I > FAST_LIMIT);
  assign teach_err  = teach_slow | teach_fast;
  assign teach_ok   = TEACH_DONE_I & ~teach_err;

  // ----------------------------------------------------------
  // Operator state machine
  // ----------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q    <= ST_READ;
      sel_q   <= SEL_MODE;
      edit_q  <= 7'h00;
      emode_q <= MODE_RST;
      fine_q  <= 1'b0;
      first_q <= 1'b0;
      err_q   <= 3'h0;
    end else if (teach_err) begin
      st_q  <= ST_ERR;
      err_q <= teach_slow ? ERR_SLOW_FLASH : ERR_FAST_FLASH;
    end else begin
      unique case (st_q)
        ST_READ: begin
          if (short_ev) begin
            st_q  <= ST_SHOW;
            sel_q <= SEL_MODE;
          end
        end
        ST_SHOW: begin
          if (idle_ev) begin
            st_q <= ST_READ;
          end else if (short_ev) begin
            if (sel_q == SEL_TMO) begin
              st_q <= ST_READ;
            end else begin
              sel_q <= sel_q + 3'h1;
            end
          end else if (long_ev) begin
            if (sel_q == SEL_MODE) begin
              st_q    <= ST_MODE;
              emode_q <= mode_q;
            end else begin
              st_q    <= ST_EDIT;
              edit_q  <= base;
              first_q <= 1'b1;
              fine_q  <= 1'b0;
            end
          end
        end
        ST_MODE: begin
          if (idle_ev || short_ev) begin
            st_q <= ST_READ;
          end else if (pace_ev) begin
            emode_q <= ~emode_q;
          end
        end
        ST_EDIT: begin
          if (idle_ev || short_ev) begin
            st_q <= ST_READ;
          end else if (long_ev) begin
            if (fine_q) begin
              edit_q <= edit_dec;
            end else begin
              edit_q  <= base;
              first_q <= 1'b1;
            end
          end else if (pace_ev) begin
            if (fine_q) begin
              if (f_ok) begin
                edit_q <= nxt_f;
              end
            end else if (c_ok) begin
              edit_q <= nxt_c;
              if ((nxt_c % DECADE) == 7'h00) begin
                first_q <= 1'b0;
              end
            end
          end else if (btn_fall) begin
            fine_q <= ~fine_q;
          end
        end
        ST_ERR: begin
          if (short_ev) begin
            st_q <= ST_READ;
          end
        end
        default: begin
          st_q <= ST_READ;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Parameters and register bus
  // ----------------------------------------------------------
  assign commit_mode = (st_q == ST_MODE) & short_ev;
  assign commit_num  = (st_q == ST_EDIT) & short_ev;
  assign wb_req  = CYC_I & STB_I & ~ack_q;
  assign wb_wr   = wb_req & WE_I;
  assign wr_cfg  = wb_wr & (ADR_I == CFG_OFS);
  assign wr_def  = wb_wr & (ADR_I == CTRL_OFS) & SEL_I[0]
                 & DAT_I[CTRL_DEF_BIT];
  assign cfg_chg = wr_def | wr_cfg | commit_mode | commit_num;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q <= MODE_RST;
      low_q  <= LOW_RST;
      high_q <= HIGH_RST;
      tmo_q  <= TMO_RST;
    end else if (wr_def) begin
      mode_q <= MODE_RST;
      low_q  <= LOW_RST;
      high_q <= HIGH_RST;
      tmo_q  <= TMO_RST;
    end else if (wr_cfg) begin
      if (SEL_I[0]) begin
        mode_q <= DAT_I[CFG_MODE_BIT];
      end
      if (SEL_I[1]) begin
        low_q <= DAT_I[CFG_LOW_LSB +: 7];
      end
      if (SEL_I[2]) begin
        high_q <= DAT_I[CFG_HIGH_LSB +: 7];
      end
      if (SEL_I[3]) begin
        tmo_q <= DAT_I[CFG_TMO_LSB +: 7];
      end
    end else if (commit_mode) begin
      mode_q <= emode_q;
    end else if (commit_num) begin
      if (sel_q == SEL_LOW) begin
        low_q <= shown;
      end else if (sel_q == SEL_HIGH) begin
        high_q <= shown;
      end else begin
        tmo_q <= shown;
      end
    end
  end

  assign cfg_word  = {1'b0, tmo_q, 1'b0, high_q, 1'b0, low_q,
                      7'h00, mode_q};
  assign stat_word = {8'h00, fs_q, 1'b0, vel_q, 1'b0, st_q,
                      (st_q == ST_ERR), relay_q};
  assign rdata = (ADR_I == CFG_OFS)  ? cfg_word
               : (ADR_I == STAT_OFS) ? stat_word : 32'h0000_0000;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      fs_q  <= FS_RST;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= rdata;
      end
      if (teach_ok) begin
        fs_q <= TEACH_MAX_I;
      end
    end
  end

  // ----------------------------------------------------------
  // Relay comparator
  // ----------------------------------------------------------
  assign in_win    = (vel_q >= alow_q) & (vel_q < ahigh_q);
  assign want      = amode_q ? in_win
                   : (vel_q >= ahigh_q) | (relay_q & (vel_q > alow_q));
  assign tmo_ticks = 14'(tmo_q) * SEC_TICKS;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      vel_q     <= 7'h00;
      amode_q   <= MODE_RST;
      alow_q    <= LOW_RST;
      ahigh_q   <= HIGH_RST;
      persist_q <= 14'h0000;
      relay_q   <= 1'b0;
    end else begin
      if (VEL_VALID_I) begin
        vel_q   <= VELOCITY_I;
        amode_q <= mode_q;
        alow_q  <= low_q;
        ahigh_q <= high_q;
      end
      if (want == relay_q || cfg_chg) begin
        persist_q <= 14'h0000;
      end else if (tick) begin
        persist_q <= persist_q + 14'h0001;
      end
      if (want != relay_q) begin
        if (tmo_q == 7'h00) begin
          relay_q <= want;
        end else if (tick && !cfg_chg && persist_q == tmo_ticks) begin
          relay_q <= want;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // LEDs and bargraph
  // ----------------------------------------------------------
  assign half_on = (ftick_q < (FLASH_TICKS >> 1));
  assign show_v  = (sel_q == SEL_LOW)  ? low_q
                 : (sel_q == SEL_HIGH) ? high_q : tmo_q;
  assign disp_v  = (st_q == ST_EDIT) ? shown
                 : (st_q == ST_SHOW) ? show_v : vel_q;
  assign disp_c  = disp_v / DECADE;
  assign disp_f  = disp_v % DECADE;
  assign bar_fl  = half_on & ({3'h0, slot_q} < disp_f);

  for (genvar i = 0; i < BAR_LEDS; i++) begin : g_bar
    assign bar_lvl[i] = (7'(i) < disp_c) | ((7'(i) == disp_c) & bar_fl);
  end

  assign show_mode  = (st_q == ST_MODE)
                    | ((st_q == ST_SHOW) & (sel_q == SEL_MODE));
  assign mode_shown = (st_q == ST_MODE) ? emode_q : mode_q;
  assign bar_d      = show_mode ? (mode_shown ? WIN_BAR : HYST_BAR)
                    : (st_q == ST_ERR) ? 10'h000 : bar_lvl;
  assign green_cnt  = (st_q == ST_READ) ? 4'h1
                    : (st_q == ST_SHOW) ? {1'b0, sel_q} + 4'h1
                    : 4'h0;
  assign green_d    = half_on & (slot_q < green_cnt);
  assign red_d      = (st_q == ST_MODE) | (st_q == ST_EDIT)
                    | ((st_q == ST_ERR) & half_on
                       & (slot_q < {1'b0, err_q}));

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ftick_q <= 5'h00;
      slot_q  <= 4'h0;
      green_q <= 1'b0;
      red_q   <= 1'b0;
      bar_q   <= 10'h000;
    end else begin
      if (tick) begin
        if (ftick_q == FLASH_TICKS - 5'h01) begin
          ftick_q <= 5'h00;
          slot_q  <= (slot_q == CYCLE_SLOTS - 4'h1) ? 4'h0
                   : slot_q + 4'h1;
        end else begin
          ftick_q <= ftick_q + 5'h01;
        end
      end
      green_q <= green_d;
      red_q   <= red_d;
      bar_q   <= bar_d;
    end
  end

  assign DAT_O       = dat_q;
  assign ACK_O       = ack_q;
  assign RELAY_O     = relay_q;
  assign LED_GREEN_O = green_q;
  assign LED_RED_O   = red_q;
  assign BAR_O       = bar_q;
  assign FULLSCALE_O = fs_q;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  chk_zero_timeout: assert property (
    (tmo_q == 7'h00) |=> (relay_q == $past(want)))
    else $error("relay not immediate at zero time-out");
  chk_timeout_wait: assert property (
    (tmo_q != 7'h00) && (persist_q < tmo_ticks) |=> $stable(relay_q))
    else $error("relay switched before time-out");
  chk_window_mode: assert property (
    amode_q && (tmo_q == 7'h00) |=> (relay_q == $past(in_win)))
    else $error("window relay wrong");
  chk_hyst_band: assert property (
    !amode_q && (vel_q > alow_q) && (vel_q < ahigh_q) |=> $stable(relay_q))
    else $error("hysteresis band changed relay");
  chk_cfg_red: assert property (
    (st_q == ST_MODE) || (st_q == ST_EDIT) |=> LED_RED_O)
    else $error("red off in config");
  chk_readout_red: assert property (
    (st_q == ST_READ) |=> !LED_RED_O)
    else $error("red on in readout");
  chk_short_select: assert property (
    (st_q == ST_READ) && short_ev && !teach_err
    |=> (st_q == ST_SHOW) && (sel_q == SEL_MODE))
    else $error("short press did not select mode");
  chk_idle_exit: assert property (
    idle_ev && !teach_err && !wr_cfg && !wr_def
    |=> (st_q == ST_READ) && $stable(low_q) && $stable(high_q))
    else $error("inactivity exit failed");
  chk_slow_error: assert property (
    teach_slow |=> (st_q == ST_ERR) && (err_q == ERR_SLOW_FLASH))
    else $error("slow range error not flagged");
  chk_low_commit: assert property (
    commit_num && (sel_q == SEL_LOW) && !wr_cfg && !wr_def
    |=> (low_q <= high_q))
    else $error("low threshold above high");

  cov_edit_commit: cover property (
    (st_q == ST_EDIT) && short_ev ##1 (st_q == ST_READ));
  cov_relay_on: cover property (!relay_q ##1 relay_q);
  cov_error_exit: cover property (
    (st_q == ST_ERR) ##[1:100] (st_q == ST_READ));
endmodule : relay_ui
`default_nettype wire

// ---- logic/relay_ui_pkg.sv ----
`default_nettype none
package relay_ui_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_KHZ     = 20000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int HOLD_MS     = 2000;
  localparam int IDLE_MS     = 10000;
  localparam int SEC_MS      = 1000;
  localparam int STEP_MS     = 400;
  localparam int ALT_MS      = 1000;
  localparam int FLASH_MS    = 200;
  localparam int DEB_MS      = 20;
  localparam logic [7:0]  HOLD_TICKS  = 8'(HOLD_MS / TICK_MS);
  localparam logic [9:0]  IDLE_TICKS  = 10'(IDLE_MS / TICK_MS);
  localparam logic [13:0] SEC_TICKS   = 14'(SEC_MS / TICK_MS);
  localparam logic [6:0]  STEP_TICKS  = 7'(STEP_MS / TICK_MS);
  localparam logic [6:0]  ALT_TICKS   = 7'(ALT_MS / TICK_MS);
  localparam logic [4:0]  FLASH_TICKS = 5'(FLASH_MS / TICK_MS);
  localparam logic [1:0]  DEB_TICKS   = 2'(DEB_MS / TICK_MS);
  localparam logic [3:0]  CYCLE_SLOTS = 4'hc;
  // ------------------------------------------------------------
  // Values and limits
  // ------------------------------------------------------------
  localparam logic [7:0] SLOW_LIMIT     = 8'h14;
  localparam logic [7:0] FAST_LIMIT     = 8'h64;
  localparam logic [2:0] ERR_SLOW_FLASH = 3'h4;
  localparam logic [2:0] ERR_FAST_FLASH = 3'h5;
  localparam logic [6:0] PCT_FULL       = 7'h64;
  localparam logic [6:0] TMO_MAX        = 7'h64;
  localparam logic [6:0] DECADE         = 7'h0a;
  localparam logic [6:0] FINE_TOP       = 7'h09;
  localparam logic [9:0] HYST_BAR       = 10'h01f;
  localparam logic [9:0] WIN_BAR        = 10'h3e0;
  localparam int         BAR_LEDS       = 10;
  localparam logic [2:0] SEL_MODE       = 3'h1;
  localparam logic [2:0] SEL_LOW        = 3'h2;
  localparam logic [2:0] SEL_HIGH       = 3'h3;
  localparam logic [2:0] SEL_TMO        = 3'h4;
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  localparam logic [3:0] CFG_OFS      = 4'h0;
  localparam logic [3:0] STAT_OFS     = 4'h4;
  localparam logic [3:0] CTRL_OFS     = 4'h8;
  localparam int         CFG_MODE_BIT = 0;
  localparam int         CFG_LOW_LSB  = 8;
  localparam int         CFG_HIGH_LSB = 16;
  localparam int         CFG_TMO_LSB  = 24;
  localparam int         CTRL_DEF_BIT = 0;
  localparam logic       MODE_RST     = 1'b0;
  localparam logic [6:0] LOW_RST      = 7'h64;
  localparam logic [6:0] HIGH_RST     = 7'h64;
  localparam logic [6:0] TMO_RST      = 7'h00;
  localparam logic [7:0] FS_RST       = 8'h64;

  typedef enum logic [4:0] {
    ST_READ = 5'b00001,
    ST_SHOW = 5'b00010,
    ST_MODE = 5'b00100,
    ST_EDIT = 5'b01000,
    ST_ERR  = 5'b10000
  } ui_state_type;
endpackage : relay_ui_pkg
`default_nettype wire

// ---- sim/front_panel.sv ----
`timescale 1ns/1ps
`default_nettype none
module front_panel #(
  parameter int TICK = 10
) (
  input  wire logic clk_i,
  output var  logic button_o
);
  // ----------------
  // Push-button
  // ----------------
  initial button_o = 1'b0;
  task automatic press(input int ticks);
    @(posedge clk_i);
    button_o <= 1'b1;
    repeat (ticks * TICK) @(posedge clk_i);
    button_o <= 1'b0;
    repeat (20 * TICK) @(posedge clk_i);
  endtask : press
endmodule : front_panel
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import relay_ui_pkg::*;
  localparam int TK = 10;
  logic        clk, rst, btn, vv, td, we, cyc, stb, ack, relay, grn, red;
  logic [6:0]  vel;
  logic [7:0]  tmax, fs;
  logic [3:0]  adr, sel;
  logic [31:0] dw, dr;
  logic [9:0]  bar;
  logic [31:0] seed = 32'hefc2;
  logic [63:0] expq[$];
  int          miscompares = 0;
  int          total_checks = 0;
  int          flashes;
  // ----------------
  // Design and panel
  // ----------------
  relay_ui #(.TICK_CYC(TK)) uut (.REF_CLK_I(clk), .RST_I(rst),
    .BUTTON_I(btn), .VELOCITY_I(vel), .VEL_VALID_I(vv),
    .TEACH_DONE_I(td), .TEACH_MAX_I(tmax), .ADR_I(adr), .DAT_I(dw),
    .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dr),
    .ACK_O(ack), .RELAY_O(relay), .LED_GREEN_O(grn), .LED_RED_O(red),
    .BAR_O(bar), .FULLSCALE_O(fs));
  front_panel #(.TICK(TK)) panel (.clk_i(clk), .button_o(btn));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [6:0] rnd(input int base, input int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 7'(base + seed % span);
  endfunction : rnd
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wb(bit w, logic [3:0] a, logic [31:0] d, e, m);
    if (!w) expq.push_back({m, e});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= w ? m[3:0] : 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    wb(1'b0, a, 32'h0, e, m);
  endtask : rd
  task automatic count_green(output int n);
    logic p;
    n = 0;
    p = grn;
    repeat (int'(CYCLE_SLOTS) * int'(FLASH_TICKS) * TK) begin
      @(posedge clk);
      if (grn === 1'b1 && p !== 1'b1) n++;
      p = grn;
    end
  endtask : count_green
  task automatic pulse(bit t, logic [7:0] v);
    @(posedge clk);
    if (t) tmax <= v;
    else vel <= v[6:0];
    td <= t;
    vv <= !t;
    @(posedge clk);
    td <= 1'b0;
    vv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // ----------------
  // Monitor, clock, watchdog
  // ----------------
  always @(posedge clk) begin : mon
    logic [63:0] e;
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      check("DAT_O", dr & e[63:32], e[31:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    {rst, vv, td, we, cyc, stb, adr, sel, dw, vel, tmax} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(CFG_OFS, 32'h00646400, 32'hffffffff);
    rd(4'hc, 32'h0, 32'hffffffff);
    wb(1'b1, CFG_OFS, 32'h003c1e00, 0, 32'hf);
    rd(CFG_OFS, 32'h003c1e00, 32'hffffffff);
    pulse(0, rnd(60, 40));
    rd(STAT_OFS, 32'h1, 32'h1);
    pulse(0, 8'd45);
    rd(STAT_OFS, 32'h1, 32'h1);
    pulse(0, rnd(0, 30));
    rd(STAT_OFS, 32'h0, 32'h1);
    wb(1'b1, CFG_OFS, 32'h003c1e01, 0, 32'hf);
    pulse(0, 8'd45);
    rd(STAT_OFS, 32'h1, 32'h1);
    pulse(0, rnd(60, 40));
    rd(STAT_OFS, 32'h0, 32'h1);
    wb(1'b1, CFG_OFS, 32'h013c1e00, 0, 32'hf);
    pulse(0, rnd(60, 40));
    repeat (500) @(posedge clk);
    rd(STAT_OFS, 32'h0, 32'h1);
    repeat (700) @(posedge clk);
    rd(STAT_OFS, 32'h1, 32'h1);
    check("RELAY_O", 32'(relay), 32'h1);
    pulse(1, 8'h0a);
    rd(STAT_OFS, 32'h00640042, 32'h00ff007e);
    panel.press(20);
    rd(STAT_OFS, 32'h00640004, 32'h00ff007e);
    pulse(1, 8'h32);
    pulse(1, 8'hc8);
    check("FULLSCALE_O", 32'(fs), 32'h32);
    rd(STAT_OFS, 32'h00320042, 32'h00ff007e);
    panel.press(20);
    check("LED_RED_O", 32'(red), 32'h0);
    count_green(flashes);
    check("LED_GREEN_O", flashes, 32'h1);
    for (int i = 1; i <= 5; i++) begin
      panel.press(20);
      rd(STAT_OFS, (i < 5) ? 32'h8 : 32'h4, 32'h7c);
      count_green(flashes);
      check("LED_GREEN_O", flashes, (i < 5) ? i + 1 : 1);
    end
    panel.press(20);
    panel.press(220);
    rd(STAT_OFS, 32'h10, 32'h7c);
    check("LED_RED_O", 32'(red), 32'h1);
    check("BAR_O", 32'(bar), 32'h01f);
    repeat (1100 * TK) @(posedge clk);
    rd(STAT_OFS, 32'h4, 32'h7c);
    rd(CFG_OFS, 32'h013c1e00, 32'hffffffff);
    panel.press(20);
    panel.press(20);
    panel.press(900);
    rd(STAT_OFS, 32'h20, 32'h7c);
    check("BAR_O", 32'(bar), 32'h03f);
    panel.press(20);
    rd(CFG_OFS, 32'h013c3c00, 32'hffffffff);
    wb(1'b1, CFG_OFS, 32'h7f7f7f01, 0, 32'h1);
    rd(CFG_OFS, 32'h013c3c01, 32'hffffffff);
    wb(1'b1, CTRL_OFS, 32'h1, 0, 32'hf);
    rd(CFG_OFS, 32'h00646400, 32'hffffffff);
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
